// ### timer_one_pkg.sv
// Package: register map, field layout and shared types for the 16-bit timer
package timer_one_pkg;

  // Register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] CONTROL_ADDR = 8'h10;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'h14;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'h18;
  localparam logic [7:0] FLAG_ADDR = 8'h1c;
  localparam logic [7:0] ENABLE_ADDR = 8'h20;
  localparam logic [7:0] STATUS_ADDR = 8'h24;

  // Control field positions
  localparam int RUN_BIT = 0;
  localparam int SOURCE_BIT = 1;
  localparam int SYNC_OFF_BIT = 2;
  localparam int OSC_EN_BIT = 3;
  localparam int PRESCALE_LO = 4;
  localparam int PRESCALE_HI = 5;
  localparam logic [7:0] CONTROL_MASK = 8'h3f;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Flag and enable registers: overflow sits in bit 0
  localparam int OVF_BIT = 0;

  // Counter limits
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // Instruction cycle is four oscillator clocks
  localparam logic [1:0] QUARTER_LAST = 2'h3;

  // Prescaler is a 3-bit ripple-style counter
  localparam logic [2:0] PRE_ZERO = 3'h0;
  localparam logic [2:0] PRE_ONE = 3'h1;

  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded control settings
  typedef struct packed {
    logic [1:0] prescale;
    logic osc_en;
    logic sync_off;
    logic source_ext;
    logic run;
  } control_t;

  // Oscillator pin pair: input value, output value, output enable
  typedef struct packed {
    logic [1:0] pin_in;
    logic [1:0] port_out;
    logic [1:0] port_dir_out;
  } osc_pins_t;

endpackage : timer_one_pkg

// ### edge_prescaler.sv
// Prescaler: counts qualifying edges and emits one pulse per 1/2/4/8
`timescale 1ns/10ps
`default_nettype none
module edge_prescaler
  import timer_one_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clear_i,
  input wire logic tick_i,
  input wire logic [1:0] prescale_i,
  output logic pulse_o
);

  logic [2:0] stage;
  logic [2:0] next_stage;
  logic [2:0] mask;

  // Division mask; 00 gives 1:1 so every tick passes
  always_comb
  begin
    unique case (prescale_i)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h1;
      2'h2: mask = 3'h3;
      2'h3: mask = 3'h7;
    endcase
    next_stage = stage + PRE_ONE;
  end

  // Pulse when the masked count wraps
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || clear_i)
    begin
      stage <= PRE_ZERO;
      pulse_o <= 1'b0;
    end
    else
    begin
      pulse_o <= tick_i && ((stage & mask) == mask);
      if (tick_i)
        stage <= next_stage & mask;
    end
  end

endmodule : edge_prescaler
`default_nettype wire

// ### timer_one.sv
// Top: 16-bit timer/counter with AXI4-Lite registers
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module timer_one
  import timer_one_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins and system events
  input wire logic ext_clock_pin_i,
  input wire logic osc_input_pin_i,
  input wire logic special_event_i,
  input wire logic sleep_i,
  input wire logic [1:0] port_dir_i,
  input wire logic [1:0] port_in_i,
  output logic [1:0] port_read_o,
  output logic [1:0] pin_oe_o,
  output logic osc_inverter_on_o,
  output logic overflow_irq_o
);

  logic [7:0] control_reg;
  control_t ctl;
  logic [15:0] count;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic armed;
  logic ext_raw;
  logic ext_rise;
  logic ext_fall;
  logic [1:0] quarter;
  logic tick;
  logic pre_pulse;
  logic inc;
  logic wrap;
  logic [15:0] next_count;
  // Write channel capture
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic [31:0] read_word;
  logic read_hit;

  assign ctl = control_t'(control_reg[5:0]);

  // Byte-lane write merge, used for the control and count register writes
  function automatic logic [7:0] lane0(input logic [7:0] old,
                                       input logic [31:0] data,
                                       input logic [3:0] strb);
    lane0 = strb[0] ? data[7:0] : old;
  endfunction : lane0

  // External edge source by oscillator enable
  assign ext_raw = ctl.osc_en ? osc_input_pin_i : ext_clock_pin_i;

  // Two-flop synchroniser plus a delay flop; edge logic compares the second and third flops
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end
    else
    begin
      ext_meta <= ext_raw;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  assign ext_rise = ext_sync && !ext_prev;
  assign ext_fall = !ext_sync && ext_prev;

  // Falling-edge arming after enable in counter mode
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || !ctl.run || !ctl.source_ext)
      armed <= 1'b0;
    else if (ext_fall)
      armed <= 1'b1;
  end

  // Instruction-cycle divider, one tick per four clocks
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      quarter <= 2'h0;
    else
      quarter <= quarter + 2'h1;
  end

  // Source select; sync bit ignored for internal clock
  always_comb
  begin
    if (ctl.source_ext)
      tick = ctl.run && armed && ext_rise;
    else
      tick = ctl.run && (quarter == QUARTER_LAST);
  end

  // Prescaler keeps counting in sleep
  edge_prescaler u_prescaler (
    .sys_clk_i (sys_clk_i),
    .rst_n_i (rst_n_i),
    .clear_i (!ctl.run),
    .tick_i (tick),
    .prescale_i (ctl.prescale),
    .pulse_o (pre_pulse)
  );

  // Synchronized counter halts in sleep; timer and async keep going
  assign inc = pre_pulse && !(sleep_i && ctl.source_ext && !ctl.sync_off);
  assign wrap = inc && (count == COUNT_MAX);
  assign next_count = count + COUNT_ONE;

  // Bus write acceptance, address and data in either order
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
    else if (do_write)
      aw_held <= 1'b0;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
    else if (do_write)
      w_held <= 1'b0;
  end

  // Ready is registered; one accept per transaction
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else
    begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_held && !s_axi_wready && !s_axi_bvalid;
    end
  end

  // Write response; unmapped addresses answer SLVERR
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      unique case (aw_addr)
        CONTROL_ADDR, COUNT_LOW_ADDR, COUNT_HIGH_ADDR,
        FLAG_ADDR, ENABLE_ADDR, STATUS_ADDR:
          s_axi_bresp <= RESP_OKAY;
        default:
          s_axi_bresp <= RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Control register; bits 7-6 never stored
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      control_reg <= CONTROL_RESET;
    else if (do_write && aw_addr == CONTROL_ADDR)
      control_reg <= lane0(control_reg, w_data, w_strb) & CONTROL_MASK;
  end

  // Counter: event clear beats software write beats increment
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      count <= COUNT_ZERO;
    else if (special_event_i)
      count <= COUNT_ZERO;
    else if (do_write && aw_addr == COUNT_LOW_ADDR)
      count[7:0] <= lane0(count[7:0], w_data, w_strb);
    else if (do_write && aw_addr == COUNT_HIGH_ADDR)
      count[15:8] <= lane0(count[15:8], w_data, w_strb);
    else if (inc)
      count <= next_count;
  end

  // Overflow flag; a wrap in the clearing cycle wins
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      overflow_flag <= 1'b0;
    else if (wrap)
      overflow_flag <= 1'b1;
    else if (do_write && aw_addr == FLAG_ADDR && w_strb[0])
      overflow_flag <= w_data[OVF_BIT];
  end

  // Overflow enable register
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
      overflow_irq_enable <= 1'b0;
    else if (do_write && aw_addr == ENABLE_ADDR && w_strb[0])
      overflow_irq_enable <= w_data[OVF_BIT];
  end

  // Gated request and pin control, all registered
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      overflow_irq_o <= 1'b0;
      pin_oe_o <= 2'h0;
      port_read_o <= 2'h0;
      osc_inverter_on_o <= 1'b0;
    end
    else
    begin
      overflow_irq_o <= (overflow_flag || wrap) && overflow_irq_enable;
      // Oscillator forces inputs and masks the port reading
      pin_oe_o <= ctl.osc_en ? 2'h0 : ~port_dir_i;
      port_read_o <= ctl.osc_en ? 2'h0 : port_in_i;
      osc_inverter_on_o <= ctl.osc_en;
    end
  end

  // Read decode
  always_comb
  begin
    read_hit = 1'b1;
    read_word = 32'h00000000;
    unique case (s_axi_araddr)
      CONTROL_ADDR: read_word[7:0] = control_reg;
      COUNT_LOW_ADDR: read_word[7:0] = count[7:0];
      COUNT_HIGH_ADDR: read_word[7:0] = count[15:8];
      FLAG_ADDR: read_word[OVF_BIT] = overflow_flag;
      ENABLE_ADDR: read_word[OVF_BIT] = overflow_irq_enable;
      STATUS_ADDR: read_word[1:0] = {ext_sync, armed};
      default: read_hit = 1'b0;
    endcase
  end

  // Read channel: accept, answer next cycle, hold until taken
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= read_word;
      s_axi_rresp <= read_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid)
    begin
      if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
    else
      s_axi_arready <= !s_axi_arready;
  end

endmodule : timer_one
`default_nettype wire

// ### timer_one_checker.sv
// Checker: bus handshakes and oscillator pin relations
`timescale 1ns/10ps
`default_nettype none
module timer_one_checker
  import timer_one_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] port_dir_i,
  input wire logic [1:0] port_read_o,
  input wire logic [1:0] pin_oe_o,
  input wire logic osc_inverter_on_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  sequence aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  // Two steady cycles, so registered pin outputs have caught up
  sequence osc_on;
    osc_inverter_on_o ##1 osc_inverter_on_o;
  endsequence
  sequence osc_off;
    !osc_inverter_on_o && $past(rst_n_i) ##1 !osc_inverter_on_o;
  endsequence
  write_answer_a: assert property (aw_taken |-> ##[1:8] s_axi_bvalid)
    else $error("write reply missing");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write reply repeated");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read reply late");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  pins_input_a: assert property (osc_on |-> pin_oe_o == 2'h0)
    else $error("pin driven with oscillator on");
  port_zero_a: assert property (osc_on |-> port_read_o == 2'h0)
    else $error("pin read nonzero");
  pin_dir_a: assert property (osc_off |-> pin_oe_o == ~$past(port_dir_i))
    else $error("pin enable ignores direction");
endmodule : timer_one_checker
bind timer_one timer_one_checker chk (.sys_clk_i, .rst_n_i, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .port_dir_i, .port_read_o, .pin_oe_o,
  .osc_inverter_on_o);
`default_nettype wire

// ### pulse_source.sv
// Partner: external count clock, idle low between bursts
`timescale 1ns/10ps
`default_nettype none
module pulse_source
(
  input wire logic sys_clk_i,
  output logic pin_o
);
  initial pin_o = 1'b0;
  // Each level held two clocks or more, so the synchroniser sees it
  task automatic send(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge sys_clk_i);
      pin_o <= 1'b1;
      repeat (half) @(posedge sys_clk_i);
      pin_o <= 1'b0;
    end
  endtask : send
endmodule : pulse_source
`default_nettype wire

// ### timer_one_bench.sv
// Testbench: register bus, count modes, wrap, pins
`timescale 1ns/10ps
`default_nettype none
module timer_one_bench
  import timer_one_pkg::*;
;
  typedef struct packed {
    logic [7:0] ctrl;
    logic sleep;
    logic [15:0] inc;
  } row_t;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, osc_inverter_on_o, overflow_irq_o, src_pin;
  logic [1:0] s_axi_bresp, s_axi_rresp, port_read_o, pin_oe_o, resp;
  logic [31:0] s_axi_rdata, rd, cnt;
  logic special_event_i = 1'b0;
  logic sleep_i = 1'b0;
  logic osc_sel = 1'b0;
  logic [1:0] port_dir_i = 2'h0;
  logic [1:0] port_in_i = 2'h2;
  wire ext_clock_pin_i = !osc_sel && src_pin;
  wire osc_input_pin_i = osc_sel && src_pin;
  int failures = 0;
  int checks = 0;
  // Nine pulses from idle low: the first rising edge is never counted
  row_t rows [8] = '{'{8'h03, 1'h0, 16'h0008}, '{8'h13, 1'h0, 16'h0004},
    '{8'h27, 1'h0, 16'h0002}, '{8'h33, 1'h0, 16'h0001},
    '{8'h0b, 1'h0, 16'h0008}, '{8'h03, 1'h1, 16'h0000},
    '{8'h07, 1'h1, 16'h0008}, '{8'h02, 1'h0, 16'h0000}};

  timer_one dut (.sys_clk_i, .rst_n_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ext_clock_pin_i, .osc_input_pin_i, .special_event_i, .sleep_i,
    .port_dir_i, .port_in_i, .port_read_o, .pin_oe_o, .osc_inverter_on_o,
    .overflow_irq_o);
  pulse_source src (.sys_clk_i, .pin_o(src_pin));

  always #20 sys_clk_i = ~sys_clk_i;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No cycle budget here: a missing reply is left to the watchdog
    forever
    begin
      @(posedge sys_clk_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    @(posedge sys_clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge sys_clk_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd_reg

  task automatic rd_count;
    rd_reg(COUNT_LOW_ADDR);
    cnt = rd;
    rd_reg(COUNT_HIGH_ADDR);
    cnt[15:8] = rd[7:0];
  endtask : rd_count

  // Hang guard: the whole run needs well under two thousand cycles
  initial
  begin
    repeat (30000) @(posedge sys_clk_i);
    failures++;
    give_verdict();
  end

  initial
  begin
    repeat (20) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd_reg(CONTROL_ADDR);
    check(rd, 32'h0);
    foreach (rows[i])
    begin
      wr(CONTROL_ADDR, {24'h0, rows[i].ctrl & 8'hfe});
      wr(COUNT_LOW_ADDR, 32'h0);
      wr(COUNT_HIGH_ADDR, 32'h0);
      sleep_i <= rows[i].sleep;
      osc_sel <= rows[i].ctrl[3];
      wr(CONTROL_ADDR, {24'h0, rows[i].ctrl});
      src.send(9, 2 + 3 * (i % 2));
      repeat (8) @(posedge sys_clk_i);
      wr(CONTROL_ADDR, 32'h0);
      sleep_i <= 1'b0;
      rd_count();
      check(cnt, {16'h0, rows[i].inc});
    end
    // Wrap through the maximum with the request masked, then unmasked
    wr(COUNT_LOW_ADDR, 32'hfe);
    wr(COUNT_HIGH_ADDR, 32'hff);
    wr(CONTROL_ADDR, 32'h03);
    src.send(4, 2);
    repeat (8) @(posedge sys_clk_i);
    wr(CONTROL_ADDR, 32'h0);
    rd_count();
    check(cnt, 32'h1);
    rd_reg(FLAG_ADDR);
    check(rd, 32'h1);
    check({31'h0, overflow_irq_o}, 32'h0);
    wr(ENABLE_ADDR, 32'h1);
    repeat (2) @(posedge sys_clk_i);
    check({31'h0, overflow_irq_o}, 32'h1);
    wr(FLAG_ADDR, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    check({31'h0, overflow_irq_o}, 32'h0);
    wr(COUNT_LOW_ADDR, 32'h5a);
    wr(COUNT_HIGH_ADDR, 32'ha5);
    rd_count();
    check(cnt, 32'ha55a);
    special_event_i <= 1'b1;
    @(posedge sys_clk_i);
    special_event_i <= 1'b0;
    rd_count();
    check(cnt, 32'h0);
    // Timer mode at 1:8: one step per 32 clocks, bus cycles add a little
    wr(CONTROL_ADDR, 32'h35);
    repeat (320) @(posedge sys_clk_i);
    wr(CONTROL_ADDR, 32'h0);
    rd_count();
    check({31'h0, cnt >= 32'd9 && cnt <= 32'd12}, 32'h1);
    port_dir_i <= 2'h1;
    wr(CONTROL_ADDR, 32'hff);
    rd_reg(CONTROL_ADDR);
    check(rd, 32'h3f);
    check({31'h0, osc_inverter_on_o}, 32'h1);
    check({28'h0, pin_oe_o, port_read_o}, 32'h0);
    wr(CONTROL_ADDR, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    check({31'h0, osc_inverter_on_o}, 32'h0);
    check({28'h0, pin_oe_o, port_read_o}, 32'ha);
    rd_reg(8'h40);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(8'h40, 32'h0);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    // Reset in mid-run while counting with the request enabled
    wr(ENABLE_ADDR, 32'h1);
    wr(CONTROL_ADDR, 32'h35);
    repeat (64) @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    rd_reg(CONTROL_ADDR);
    check(rd, 32'h0);
    rd_reg(ENABLE_ADDR);
    check(rd, 32'h0);
    rd_count();
    check(cnt, 32'h0);
    give_verdict();
  end
endmodule : timer_one_bench
`default_nettype wire
